// ===== core/mem_arb_regs.svh
`ifndef MEM_ARB_REGS_SVH
`define MEM_ARB_REGS_SVH

// ==========================================================
// bus geometry
`define BUS_COUNT      4
`define BUS_WIDTH      11
`define PAGE_WIDTH     4
`define STREAM_WIDTH   2

// ==========================================================
// transfer lengths in clock periods
`define ADDR_BEATS     3'd2
`define DATA_BEATS     3'd3
`define CORE_CYCLES    3'd4

// ==========================================================
// output bus choice among granted buses
`define OUT_LOWEST     2'd0
`define OUT_MIDDLE     2'd1
`define OUT_HIGHEST    2'd2

`endif

// ===== core/mem_arb_pkg.sv
package mem_arb_pkg;

  // ==========================================================
  // memory timing and control sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WDATA = 3'b010,
    ST_WCORE = 3'b011,
    ST_RCORE = 3'b100,
    ST_RDATA = 3'b101
  } seq_state_type;

endpackage

// ===== core/memory_bus_access_arbiter.sv
`timescale 1ns/1ps
`include "mem_arb_regs.svh"

module memory_bus_access_arbiter
  import mem_arb_pkg::*;
#(
  parameter int NB = `BUS_COUNT,
  parameter int PW = `PAGE_WIDTH,
  parameter int SW = `STREAM_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [NB-1:0]    io_request,
  input  wire logic [NB-1:0]    cpu_request,
  input  wire logic [NB*PW-1:0] bus_page,
  input  wire logic [NB-1:0]    bus_write,
  input  wire logic [NB*SW-1:0] cpu_stream,
  input  wire logic [PW-1:0]    ccu_page,
  input  wire logic [1:0]       ccu_out_select,
  output logic      [NB-1:0]    memory_request_ack,
  output logic      [NB-1:0]    memory_data_available,
  output logic      [NB-1:0]    voter_select,
  output logic      [NB-1:0]    output_bus_select,
  output logic                  busy,
  output logic                  write_cycle
);

  // ==========================================================
  // state
  seq_state_type state_reg, state_next;
  logic [2:0]    count_reg, count_next;
  logic [NB-1:0] ack_reg, ack_next;
  logic [NB-1:0] avail_reg, avail_next;
  logic [NB-1:0] voter_reg, voter_next;
  logic [NB-1:0] outbus_reg, outbus_next;
  logic          busy_reg, busy_next;
  logic          write_reg, write_next;
  logic          cpu_seen_reg, cpu_seen_next;

  // ==========================================================
  // arbitration signals
  logic [NB-1:0] page_hit;
  logic [NB-1:0] io_hit;
  logic [NB-1:0] cpu_hit;
  logic [NB-1:0] grant;
  logic [NB-1:0] out_pick;
  logic          grant_any;
  logic          grant_write;

  // page comparators, one per processor bus
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_page
      assign page_hit[gi] = (bus_page[gi*PW +: PW] == ccu_page);
    end
  endgenerate

  assign io_hit  = io_request & page_hit;
  assign cpu_hit = cpu_request & page_hit;

  // request priority ordering and grant selection
  always_comb begin
    logic          found;
    logic [SW-1:0] lead;
    grant = '0;
    found = 1'b0;
    lead  = '0;
    if (state_reg == ST_IDLE) begin
      if (|io_hit && !(cpu_seen_reg && |cpu_hit)) begin
        for (int i = 0; i < NB; i++) begin
          if (io_hit[i] && !found) begin
            grant[i] = 1'b1;
            found    = 1'b1;
          end
        end
      end else begin
        for (int i = 0; i < NB; i++) begin
          if (cpu_hit[i] && !found) begin
            lead  = cpu_stream[i*SW +: SW];
            found = 1'b1;
          end
        end
        for (int i = 0; i < NB; i++) begin
          grant[i] = cpu_hit[i] && (cpu_stream[i*SW +: SW] == lead);
        end
      end
    end
  end

  assign grant_any = |grant;

  // read/write indication of the lowest granted bus
  always_comb begin
    grant_write = 1'b0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (grant[i]) begin
        grant_write = bus_write[i];
      end
    end
  end

  // output bus: nth granted bus per assignment, else highest granted
  always_comb begin
    logic [1:0] seen;
    out_pick = '0;
    seen     = 2'd0;
    for (int i = 0; i < NB; i++) begin
      if (grant[i]) begin
        if (seen <= ccu_out_select) begin
          out_pick = '0;
          out_pick[i] = 1'b1;
        end
        seen = seen + 2'd1;
      end
    end
  end

  // ==========================================================
  // sequencer next state and holding registers
  always_comb begin
    state_next    = state_reg;
    count_next    = count_reg;
    voter_next    = voter_reg;
    outbus_next   = outbus_reg;
    write_next    = write_reg;
    ack_next      = '0;
    cpu_seen_next = |cpu_hit && !grant_any;
    case (state_reg)
      ST_IDLE: begin
        if (grant_any) begin
          state_next  = ST_ADDR;
          count_next  = `ADDR_BEATS - 3'd1;
          voter_next  = grant;
          outbus_next = out_pick;
          write_next  = grant_write;
          ack_next    = grant;
        end
      end
      ST_ADDR: begin
        if (count_reg == 3'd0) begin
          if (write_reg) begin
            state_next = ST_WDATA;
            count_next = `DATA_BEATS - 3'd1;
          end else begin
            state_next = ST_RCORE;
            count_next = `CORE_CYCLES - 3'd1;
          end
        end else begin
          count_next = count_reg - 3'd1;
        end
      end
      ST_WDATA: begin
        if (count_reg == 3'd0) begin
          state_next = ST_WCORE;
          count_next = `CORE_CYCLES - 3'd1;
        end else begin
          count_next = count_reg - 3'd1;
        end
      end
      ST_RCORE: begin
        if (count_reg == 3'd0) begin
          state_next = ST_RDATA;
          count_next = `DATA_BEATS - 3'd1;
        end else begin
          count_next = count_reg - 3'd1;
        end
      end
      ST_WCORE, ST_RDATA: begin
        if (count_reg == 3'd0) begin
          state_next = ST_IDLE;
        end else begin
          count_next = count_reg - 3'd1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        count_next = 3'd0;
      end
    endcase
    busy_next  = (state_next != ST_IDLE);
    avail_next = (state_next == ST_RDATA) ? outbus_next : '0;
  end

  // registers, cleared by master clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      count_reg    <= 3'd0;
      ack_reg      <= '0;
      avail_reg    <= '0;
      voter_reg    <= '0;
      outbus_reg   <= '0;
      busy_reg     <= 1'b0;
      write_reg    <= 1'b0;
      cpu_seen_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      ack_reg      <= ack_next;
      avail_reg    <= avail_next;
      voter_reg    <= voter_next;
      outbus_reg   <= outbus_next;
      busy_reg     <= busy_next;
      write_reg    <= write_next;
      cpu_seen_reg <= cpu_seen_next;
    end
  end

  // outputs straight from flops
  assign memory_request_ack    = ack_reg;
  assign memory_data_available = avail_reg;
  assign voter_select          = voter_reg;
  assign output_bus_select     = outbus_reg;
  assign busy                  = busy_reg;
  assign write_cycle           = write_reg;

  // ==========================================================
  // checks
  property p_ack_page;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_IDLE && grant_any) |=> ((ack_reg & ~$past(page_hit)) == '0);
  endproperty
  a_ack_page: assert property (p_ack_page) else $error("ack on unmatched page");

  property p_no_grant_busy;
    @(posedge clock) disable iff (rst)
      (busy_reg && state_next != ST_IDLE) |=> (ack_reg == '0 && $stable(voter_reg));
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy) else $error("grant while busy");

  property p_io_first;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_IDLE && |io_hit && !cpu_seen_reg)
        |=> ((ack_reg & ~$past(io_hit)) == '0 && |ack_reg);
  endproperty
  a_io_first: assert property (p_io_first) else $error("io request not favoured");

  property p_cpu_hold;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_IDLE && cpu_seen_reg && |cpu_hit) |=> ((ack_reg & ~$past(cpu_hit)) == '0);
  endproperty
  a_cpu_hold: assert property (p_cpu_hold) else $error("io granted over pending cpu");

  // a lone cpu request on an idle memory is granted at once, on its own buses only
  property p_cpu_grant;
    @(posedge clock) disable iff (rst)
      (state_reg == ST_IDLE && !(|io_hit) && |cpu_hit)
        |=> (|ack_reg && (ack_reg & ~$past(cpu_hit)) == '0);
  endproperty
  a_cpu_grant: assert property (p_cpu_grant) else $error("cpu request not granted");

  property p_voter_load;
    @(posedge clock) disable iff (rst)
      (|ack_reg) |-> (voter_reg == ack_reg && (output_bus_select & ~voter_reg) == '0);
  endproperty
  a_voter_load: assert property (p_voter_load) else $error("holding regs not reloaded");

  property p_one_out;
    @(posedge clock) disable iff (rst)
      (|ack_reg) |-> $onehot(output_bus_select);
  endproperty
  a_one_out: assert property (p_one_out) else $error("output bus not single");

  property p_addr_two;
    @(posedge clock) disable iff (rst)
      (|ack_reg) |-> (state_reg == ST_ADDR) [*2] ##1 (state_reg != ST_ADDR);
  endproperty
  a_addr_two: assert property (p_addr_two) else $error("address not two clocks");

  property p_avail_three;
    @(posedge clock) disable iff (rst)
      $rose(|avail_reg) |-> (avail_reg == output_bus_select) [*3] ##1 (avail_reg == '0);
  endproperty
  a_avail_three: assert property (p_avail_three) else $error("avail not 3 clocks");

  property p_rw_path;
    @(posedge clock) disable iff (rst)
      (|ack_reg && write_reg) |-> (avail_reg == '0) [*8];
  endproperty
  a_rw_path: assert property (p_rw_path) else $error("write showed read data");

  property p_busy_span;
    @(posedge clock) disable iff (rst)
      (|ack_reg) |-> busy_reg [*6];
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy dropped early");

endmodule

// ===== sim/proc_side_model.sv
`timescale 1ns/1ps
// ====
// processors sharing the buses: requests held until acknowledged or dropped
module proc_side_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       drop,
  input  wire logic [3:0] io_want,
  input  wire logic [3:0] cpu_want,
  input  wire logic [3:0] ack,
  input  wire logic       busy,
  output logic      [3:0] io_request,
  output logic      [3:0] cpu_request,
  output logic            cpu_inhibit
);
  logic [3:0] io_reg, io_next, cpu_reg, cpu_next;
  logic       inh_reg, inh_next;
  // cpu may not start while any io request is up
  always_comb begin
    io_next  = (io_reg | io_want) & ~ack & ~{4{drop}};
    cpu_next = (cpu_reg | (cpu_want & {4{io_reg == 4'h0}})) & ~ack & ~{4{drop}};
    inh_next = |(cpu_reg & ack) | (inh_reg & busy);
  end
  // register the request lines
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      io_reg  <= 4'h0;
      cpu_reg <= 4'h0;
      inh_reg <= 1'b0;
    end else begin
      io_reg  <= io_next;
      cpu_reg <= cpu_next;
      inh_reg <= inh_next;
    end
  end
  assign io_request  = io_reg;
  assign cpu_request = cpu_reg;
  assign cpu_inhibit = inh_reg;
endmodule

// ===== sim/memory_bus_access_arbiter_tb_top.sv
`timescale 1ns/1ps
module memory_bus_access_arbiter_tb_top;
  logic        clock, rst, drop, busy, write_cycle;
  logic [3:0]  io_want, cpu_want, io_request, cpu_request, bus_write;
  logic [3:0]  ccu_page, ack, avail, voter, outsel, av_bus;
  logic [15:0] bus_page;
  logic [7:0]  cpu_stream;
  logic [1:0]  ccu_out_select, b;
  logic [16:0] expq[$];
  logic [16:0] cur;
  int          n_errors, total_checks, cycles, bsy_n, av_n;
  int          seed = 32'hd8a82bdb;

  // ====
  // clock and parts
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  memory_bus_access_arbiter u_dut (.clock(clock), .rst(rst), .io_request(io_request),
    .cpu_request(cpu_request), .bus_page(bus_page), .bus_write(bus_write),
    .cpu_stream(cpu_stream), .ccu_page(ccu_page), .ccu_out_select(ccu_out_select),
    .memory_request_ack(ack), .memory_data_available(avail), .voter_select(voter),
    .output_bus_select(outsel), .busy(busy), .write_cycle(write_cycle));
  proc_side_model u_proc (.clock(clock), .rst(rst), .drop(drop), .io_want(io_want),
    .cpu_want(cpu_want), .ack(ack), .busy(busy), .io_request(io_request),
    .cpu_request(cpu_request), .cpu_inhibit());

  // ====
  // helpers
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic prep(input logic [3:0] on, input logic [7:0] strm, input logic [1:0] sel);
    ccu_page = 4'($random(seed));
    bus_page = 16'($random(seed));
    for (int i = 0; i < 4; i++) if (on[i]) bus_page[4*i +: 4] = ccu_page;
    bus_write = 4'($random(seed));
    cpu_stream = strm;
    ccu_out_select = sel;
  endtask
  // note: grant, voter, output bus, direction of lowest bus, read bus
  function automatic logic [16:0] mk(input logic [3:0] g, input logic [3:0] o);
    logic w;
    w = bus_write[g[0] ? 0 : g[1] ? 1 : g[2] ? 2 : 3];
    return {g, g, o, w, w ? 4'h0 : o};
  endfunction
  task automatic req(input logic [3:0] io, input logic [3:0] cpu);
    io_want = io;
    cpu_want = cpu;
    @(posedge clock);
    #2;
    io_want = 4'h0;
    cpu_want = 4'h0;
  endtask
  task automatic settle;
    int i;
    i = 0;
    do begin
      @(posedge clock);
      #1;
      i++;
    end while (i < 60 && (busy !== 1'b0 || (io_request | cpu_request) !== 4'h0));
    check(17'(busy | (|(io_request | cpu_request))), 17'h0);
    #1;
  endtask

  // ====
  // monitor: each grant is compared with the oldest note
  always @(posedge clock) begin
    #1;
    if (ack !== 4'h0) begin
      cur = (expq.size() != 0) ? expq.pop_front() : 17'h0;
      check({ack, voter, outsel, write_cycle}, cur[16:4]);
    end
    if (busy === 1'b1) bsy_n++;
    if (avail !== 4'h0) begin
      av_n++;
      av_bus = avail;
    end
    if (busy === 1'b0 && bsy_n != 0) begin
      check({5'(bsy_n), 5'(av_n), 3'h0, av_bus},
            {5'd9, (cur[3:0] != 0) ? 5'd3 : 5'd0, 3'h0, cur[3:0]});
      bsy_n = 0;
      av_n = 0;
      av_bus = 4'h0;
    end
  end
  // cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      conclude;
    end
  end

  // ====
  // main sequence
  initial begin
    {rst, drop, io_want, cpu_want, av_bus} = {1'b1, 1'b0, 12'h0};
    prep(4'h0, 8'h0, 2'h0);
    repeat (6) @(posedge clock);
    #2;
    rst = 1'b0;
    // simplex io accesses on random buses and directions
    for (int k = 0; k < 4; k++) begin
      b = 2'($random(seed));
      prep(4'h1 << b, 8'h0, 2'($random(seed)));
      expq.push_back(mk(4'h1 << b, 4'h1 << b));
      req(4'h1 << b, 4'h0);
      settle;
    end
    // page mismatch is ignored
    prep(4'h0, 8'h0, 2'h0);
    bus_page[7:4] = ~ccu_page;
    req(4'h2, 4'h0);
    repeat (15) @(posedge clock);
    #2;
    check(17'(busy), 17'h0);
    drop = 1'b1;
    @(posedge clock);
    #2;
    drop = 1'b0;
    // io beats a new cpu request, then the pending cpu beats a later io
    prep(4'hb, 8'h0, 2'h0);
    expq.push_back(mk(4'h8, 4'h8));
    expq.push_back(mk(4'h1, 4'h1));
    expq.push_back(mk(4'h2, 4'h2));
    req(4'h8, 4'h1);
    repeat (3) @(posedge clock);
    #2;
    req(4'h2, 4'h0);
    settle;
    // triple stream with each output bus choice
    for (int s = 0; s < 3; s++) begin
      prep(4'he, 8'h54, 2'(s));
      expq.push_back(mk(4'he, 4'h2 << s));
      req(4'h0, 4'he);
      settle;
    end
    // two competing streams: one whole stream at a time
    prep(4'h7, 8'h26, 2'h2);
    expq.push_back(mk(4'h5, 4'h4));
    expq.push_back(mk(4'h2, 4'h2));
    req(4'h0, 4'h7);
    settle;
    check(17'(expq.size()), 17'h0);
    conclude;
  end
endmodule
